// ### src/adcso_accum.sv
`timescale 1ns/1ps
module adcso_accum (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic [adcso_pkg::SAMPLE_W-1:0] sample,
  input wire logic [2:0] ratio,
  input wire logic [3:0] shift,
  output logic done,
  output logic [15:0] result
);
  logic [adcso_pkg::ACC_W-1:0] acc_q;
  logic [8:0] cnt_q;
  wire [8:0] target = 9'h002 << ratio;
  wire [adcso_pkg::ACC_W-1:0] sum = acc_q + adcso_pkg::ACC_W'(sample);
  wire last = sample_valid && (cnt_q + 9'h001 == target);
  // reserved shift codes clamp to the largest documented shift
  wire [3:0] sh = (shift > adcso_pkg::SHIFT_MAX) ? adcso_pkg::SHIFT_MAX : shift;
  wire [adcso_pkg::ACC_W-1:0] shifted = sum >> sh;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      cnt_q <= '0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= last;
      if (clear || last) begin
        acc_q <= '0;
        cnt_q <= '0;
      end else if (sample_valid) begin
        acc_q <= sum;
        cnt_q <= cnt_q + 9'h001;
      end
      if (last) begin
        result <= shifted[15:0];
      end
    end
  end

  ratio_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    last |=> done) else $error("accumulation did not finish at ratio");
  shift_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sh <= adcso_pkg::SHIFT_MAX) else $error("shift beyond eight bits");
endmodule

// ### src/adcso_pkg.sv
package adcso_pkg;
  localparam logic [7:0] OFF_SEQ_HIGH = 8'h2c;
  localparam logic [7:0] OFF_SEQ_MID = 8'h30;
  localparam logic [7:0] OFF_SEQ_LOW = 8'h34;
  localparam logic [7:0] OFF_RESULT = 8'h4c;
  localparam logic [7:0] OFF_OVS_CTL = 8'h80;
  localparam logic [7:0] OFF_CONV_CTL = 8'h84;
  localparam logic [7:0] OFF_SEQ_STATUS = 8'h88;
  localparam logic [31:0] SEQ_HIGH_MASK = 32'h00ff_ffff;
  localparam logic [31:0] SEQ_MIDLOW_MASK = 32'h3fff_ffff;
  localparam logic [31:0] OVS_CTL_MASK = 32'h0000_33fd;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int LEN_LSB = 20;
  localparam int SLOT_W = 5;
  localparam logic [4:0] CHAN_MAX = 5'h11;
  localparam logic [3:0] SHIFT_MAX = 4'h8;
  localparam int SAMPLE_W = 12;
  localparam int ACC_W = 20;

  typedef struct packed {
    logic [1:0] resolution_select;
    logic triggered_oversample;
    logic [3:0] oversample_shift;
    logic [2:0] oversample_ratio;
    logic oversampler_on;
  } adcso_ovs_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } adcso_bus_t;
endpackage

// ### src/adcso_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - sequence runs length field plus one conversions; zero means one conversion.
// - each five-bit slot holds channel 0..17, converted in slot order.
// - result low half holds the latest routine value, read only.
// - in synchronous pair mode the upper half carries the partner result.
// - partner field exists only in the master instance, else reads zero.
// - resolution code 00/01/10/11 selects 12/10/8/6 bits.
// - triggered bit clear: all oversampled conversions run after one trigger.
// - triggered bit set: every oversampled conversion waits its own trigger.
// - shift field shifts accumulated sum 0..8 bits; other codes reserved.
// - ratio code 000..111 selects 2x up to 256x samples.
// - oversampling fields writable only while converter enable is zero.
// - oversampler enable bit turns the oversampler on or off.
// - converter enable clear powers down; set enables the converter.
module adcso_regs #(
  parameter bit IS_MASTER = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic trigger,
  input wire logic sample_valid,
  input wire logic [adcso_pkg::SAMPLE_W-1:0] sample,
  input wire logic sync_mode,
  input wire logic [15:0] partner_routine_result,
  output logic converter_on,
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic [1:0] resolution_select,
  output logic seq_done
);
  typedef enum logic [2:0] {
    ADCSO_IDLE = 3'b001,
    ADCSO_CONV = 3'b010,
    ADCSO_WAIT = 3'b100
  } adcso_state_t;

  adcso_state_t state_q, state_d;
  logic [31:0] seq_high_q, seq_mid_q, seq_low_q;
  adcso_pkg::adcso_ovs_t ovs_q;
  logic conv_on_q;
  logic [15:0] result_q;
  logic [15:0] partner_q;
  logic [3:0] slot_q;
  logic seq_done_q;
  logic [31:0] rdata_q;
  adcso_pkg::adcso_bus_t bus;

  assign bus = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  function automatic logic [4:0] slot_chan(input logic [3:0] n, input logic [31:0] lo,
                                           input logic [31:0] mid, input logic [31:0] hi);
    logic [4:0] c;
    c = '0;
    if (n < 4'd6) begin
      c = lo[n*adcso_pkg::SLOT_W +: adcso_pkg::SLOT_W];
    end else if (n < 4'd12) begin
      c = mid[(n-4'd6)*adcso_pkg::SLOT_W +: adcso_pkg::SLOT_W];
    end else begin
      c = hi[(n-4'd12)*adcso_pkg::SLOT_W +: adcso_pkg::SLOT_W];
    end
    return c;
  endfunction

  function automatic logic [15:0] trim_res(input logic [11:0] s, input logic [1:0] r);
    // lower resolutions keep the right-aligned top bits of the sample
    return 16'(s >> (r * 2));
  endfunction

  wire wr_seq_high = bus.wr && bus.addr == adcso_pkg::OFF_SEQ_HIGH;
  wire wr_seq_mid = bus.wr && bus.addr == adcso_pkg::OFF_SEQ_MID;
  wire wr_seq_low = bus.wr && bus.addr == adcso_pkg::OFF_SEQ_LOW;
  wire wr_ovs = bus.wr && bus.addr == adcso_pkg::OFF_OVS_CTL && !conv_on_q;
  wire wr_conv = bus.wr && bus.addr == adcso_pkg::OFF_CONV_CTL;
  wire [3:0] seq_len = seq_high_q[adcso_pkg::LEN_LSB +: 4];
  wire [4:0] chan_raw = slot_chan(slot_q, seq_low_q, seq_mid_q, seq_high_q);
  // out-of-range channels fall back to channel zero rather than a floating input
  wire [4:0] chan_sel = (chan_raw > adcso_pkg::CHAN_MAX) ? 5'h00 : chan_raw;
  wire [15:0] sample_res = trim_res(sample, ovs_q.resolution_select);
  wire accum_done;
  wire [15:0] accum_result;
  wire ovs_sample = ovs_q.oversampler_on && sample_valid && state_q == ADCSO_CONV;
  wire plain_done = !ovs_q.oversampler_on && sample_valid && state_q == ADCSO_CONV;
  wire conv_done = plain_done || accum_done;
  wire last_slot = slot_q == seq_len;

  adcso_accum u_accum (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(state_q == ADCSO_IDLE),
    .sample_valid(ovs_sample),
    .sample(sample_res[adcso_pkg::SAMPLE_W-1:0]),
    .ratio(ovs_q.oversample_ratio),
    .shift(ovs_q.oversample_shift),
    .done(accum_done),
    .result(accum_result)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADCSO_IDLE: begin
        if (conv_on_q && trigger) begin
          state_d = ADCSO_CONV;
        end
      end
      ADCSO_CONV: begin
        if (!conv_on_q) begin
          state_d = ADCSO_IDLE;
        end else if (conv_done) begin
          state_d = last_slot ? ADCSO_IDLE : ADCSO_CONV;
        end else if (ovs_sample && ovs_q.triggered_oversample) begin
          state_d = ADCSO_WAIT;
        end
      end
      ADCSO_WAIT: begin
        // the final triggered sample completes while waiting, so the sum lands here
        if (!conv_on_q) begin
          state_d = ADCSO_IDLE;
        end else if (accum_done && last_slot) begin
          state_d = ADCSO_IDLE;
        end else if (trigger) begin
          state_d = ADCSO_CONV;
        end
      end
      default: state_d = ADCSO_IDLE;
    endcase
  end

  // one start per trigger in triggered mode; back to back otherwise
  assign conv_start = state_q == ADCSO_CONV && conv_on_q;
  assign conv_channel = chan_sel;
  assign converter_on = conv_on_q;
  assign resolution_select = ovs_q.resolution_select;
  assign seq_done = seq_done_q;
  assign rdata = rdata_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ADCSO_IDLE;
      slot_q <= '0;
      seq_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      seq_done_q <= conv_done && last_slot;
      if (state_q == ADCSO_IDLE || (conv_done && last_slot)) begin
        slot_q <= '0;
      end else if (conv_done) begin
        slot_q <= slot_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_high_q <= adcso_pkg::RESET_WORD;
      seq_mid_q <= adcso_pkg::RESET_WORD;
      seq_low_q <= adcso_pkg::RESET_WORD;
      ovs_q <= '0;
      conv_on_q <= 1'b0;
    end else begin
      if (wr_seq_high) seq_high_q <= bus.wdata & adcso_pkg::SEQ_HIGH_MASK;
      if (wr_seq_mid) seq_mid_q <= bus.wdata & adcso_pkg::SEQ_MIDLOW_MASK;
      if (wr_seq_low) seq_low_q <= bus.wdata & adcso_pkg::SEQ_MIDLOW_MASK;
      if (wr_ovs) begin
        ovs_q <= '{resolution_select: bus.wdata[13:12],
                   triggered_oversample: bus.wdata[9],
                   oversample_shift: bus.wdata[8:5],
                   oversample_ratio: bus.wdata[4:2],
                   oversampler_on: bus.wdata[0]};
      end
      if (wr_conv) conv_on_q <= bus.wdata[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
      partner_q <= '0;
    end else begin
      if (plain_done) begin
        result_q <= sample_res;
      end else if (accum_done) begin
        result_q <= accum_result;
      end
      if (conv_done && IS_MASTER && sync_mode) begin
        partner_q <= partner_routine_result;
      end
    end
  end

  wire [31:0] ovs_word = {18'h0_0000, ovs_q.resolution_select, 2'b00,
                          ovs_q.triggered_oversample, ovs_q.oversample_shift,
                          ovs_q.oversample_ratio, 1'b0, ovs_q.oversampler_on};
  wire [15:0] partner_rd = IS_MASTER ? partner_q : 16'h0000;
  wire [31:0] status_word = {27'h000_0000, state_q != ADCSO_IDLE, slot_q};
  wire [31:0] rd_mux =
    (bus.addr == adcso_pkg::OFF_SEQ_HIGH) ? seq_high_q :
    (bus.addr == adcso_pkg::OFF_SEQ_MID) ? seq_mid_q :
    (bus.addr == adcso_pkg::OFF_SEQ_LOW) ? seq_low_q :
    (bus.addr == adcso_pkg::OFF_RESULT) ? {partner_rd, result_q} :
    (bus.addr == adcso_pkg::OFF_OVS_CTL) ? ovs_word :
    (bus.addr == adcso_pkg::OFF_CONV_CTL) ? {31'h0000_0000, conv_on_q} :
    (bus.addr == adcso_pkg::OFF_SEQ_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  sequence ovs_write_busy_s;
    wr_en && addr == adcso_pkg::OFF_OVS_CTL && conv_on_q;
  endsequence

  ovs_write_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovs_write_busy_s |=> $stable(ovs_q)) else $error("ovs control changed while converter on");
  ovs_write_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_ovs |=> ovs_q.oversampler_on == $past(wdata[0])) else $error("ovs enable not taken");
  seq_len_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && slot_q == seq_len |=> slot_q == 4'h0 && seq_done_q)
    else $error("sequence did not end at length");
  slot_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && !last_slot && state_q != ADCSO_IDLE |=> slot_q == $past(slot_q) + 4'h1)
    else $error("slot did not advance");
  result_plain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    plain_done |=> result_q == $past(sample_res)) else $error("result not captured");
  partner_slave_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_en && addr == adcso_pkg::OFF_RESULT && !IS_MASTER |=> rdata[31:16] == 16'h0000)
    else $error("slave shows partner data");
  trig_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ADCSO_WAIT && !trigger && conv_on_q && !accum_done |=> state_q == ADCSO_WAIT)
    else $error("left wait without trigger");

  sequence trig_take_s;
    state_q == ADCSO_IDLE && conv_on_q && trigger;
  endsequence

  sequence wait_state_s;
    state_q == ADCSO_WAIT;
  endsequence

  trig_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_take_s |=> conv_start) else $error("trigger did not start conversion");
  wait_no_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_state_s |-> !conv_start) else $error("conversion requested while waiting");
  conv_off_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !conv_on_q |=> state_q == ADCSO_IDLE) else $error("sequencer busy while off");
  chan_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_channel <= adcso_pkg::CHAN_MAX) else $error("channel out of range");
  ovs_result_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accum_done |=> result_q == $past(accum_result)) else $error("oversampled result lost");
  ovs_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovs_q.oversampler_on |-> !plain_done) else $error("plain capture while oversampling");
  res_six_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    plain_done && ovs_q.resolution_select == 2'b11 |=> result_q[15:6] == 10'h000)
    else $error("six-bit result too wide");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rd_en |=> rdata == 32'h0000_0000) else $error("read data outside read cycle");
  slave_partner_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !IS_MASTER |-> partner_rd == 16'h0000) else $error("slave holds partner data");
  power_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !conv_on_q |=> !conv_start) else $error("conversion while converter off");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_en && addr == adcso_pkg::OFF_SEQ_MID |=> rdata[31:30] == 2'b00)
    else $error("reserved bits not zero");
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } adcso_row_t;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic trigger = 1'b0;
  logic sample_valid = 1'b0;
  logic [11:0] sample = 12'h000;
  logic sync_mode = 1'b0;
  logic [15:0] partner_routine_result = 16'h0000;
  logic converter_on;
  logic conv_start;
  logic [4:0] conv_channel;
  logic [1:0] resolution_select;
  logic seq_done;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  adcso_row_t rows [6];
  logic [31:0] d;

  adcso_regs i_adcso_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .trigger(trigger), .sample_valid(sample_valid),
    .sample(sample), .sync_mode(sync_mode), .partner_routine_result(partner_routine_result),
    .converter_on(converter_on), .conv_start(conv_start), .conv_channel(conv_channel),
    .resolution_select(resolution_select), .seq_done(seq_done)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs about a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // whole 32-bit words only
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic pulse_sample(input logic [11:0] s);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample <= s;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1;
  endtask

  task automatic run_trigger();
    @(posedge sys_clk);
    trigger <= 1'b1;
    @(posedge sys_clk);
    trigger <= 1'b0;
    #1;
  endtask

  // seq_done is a one-cycle pulse, so it is looked for after every edge
  task automatic wait_done();
    logic seen;
    seen = (seq_done === 1'b1);
    for (int i = 0; i < 6 && !seen; i++) begin
      @(posedge sys_clk);
      #1 seen = (seq_done === 1'b1);
    end
    chk("seq_done", {31'h0, seen}, 32'h0000_0001);
  endtask

  initial begin
    rows[0] = '{8'h2c, 32'hffff_ffff, 32'h00ff_ffff};
    rows[1] = '{8'h30, 32'hffff_ffff, 32'h3fff_ffff};
    rows[2] = '{8'h34, 32'hffff_ffff, 32'h3fff_ffff};
    rows[3] = '{8'h80, 32'hffff_ffff, 32'h0000_33fd};
    rows[4] = '{8'h4c, 32'hffff_ffff, 32'h0000_0000};
    rows[5] = '{8'h90, 32'hffff_ffff, 32'h0000_0000};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(rows[i].addr, d);
      chk("reset value", d, 32'h0000_0000);
    end
    chk("converter_on", {31'h0, converter_on}, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk("masked readback", d, rows[i].exp);
    end
    chk("resolution", {30'h0, resolution_select}, 32'h0000_0003);
    // two-slot sequence: channel 3 then 17
    wr(8'h80, 32'h0000_0000);
    wr(8'h2c, 32'h0010_0000);
    wr(8'h34, 32'h0000_0223);
    wr(8'h84, 32'h0000_0001);
    chk("converter_on", {31'h0, converter_on}, 32'h0000_0001);
    wr(8'h80, 32'h0000_2021);
    rd(8'h80, d);
    chk("ovs locked", d, 32'h0000_0000);
    run_trigger();
    chk("conv_start", {31'h0, conv_start}, 32'h0000_0001);
    chk("slot0 channel", {27'h0, conv_channel}, 32'h0000_0003);
    pulse_sample(12'habc);
    chk("slot1 channel", {27'h0, conv_channel}, 32'h0000_0011);
    sync_mode <= 1'b1;
    partner_routine_result <= 16'h5a5a;
    pulse_sample(12'h123);
    wait_done();
    rd(8'h4c, d);
    chk("result", d, 32'h5a5a_0123);
    // oversampling 2x, shift 1: (100 + 200) >> 1 = 150
    sync_mode <= 1'b0;
    wr(8'h84, 32'h0000_0000);
    wr(8'h80, 32'h0000_0021);
    wr(8'h2c, 32'h0000_0000);
    wr(8'h84, 32'h0000_0001);
    rd(8'h80, d);
    chk("ovs ctl", d, 32'h0000_0021);
    run_trigger();
    pulse_sample(12'h064);
    pulse_sample(12'h0c8);
    wait_done();
    rd(8'h4c, d);
    chk("ovs result", {16'h0, d[15:0]}, 32'h0000_0096);
    // triggered oversampling: each sample needs its own trigger
    wr(8'h84, 32'h0000_0000);
    wr(8'h80, 32'h0000_0221);
    wr(8'h84, 32'h0000_0001);
    run_trigger();
    pulse_sample(12'h064);
    chk("triggered_oversample wait", {31'h0, conv_start}, 32'h0000_0000);
    run_trigger();
    chk("triggered_oversample restart", {31'h0, conv_start}, 32'h0000_0001);
    pulse_sample(12'h0c8);
    wait_done();
    rd(8'h4c, d);
    chk("triggered_oversample result", {16'h0, d[15:0]}, 32'h0000_0096);
    final_report();
  end
endmodule
